// [stream_cmd_pkg.sv]
package stream_cmd_pkg;

  // Command block register indices on the device register port
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_OPTIONS = 3'h1;   // command_options on write, failure_cause on read
  localparam logic [2:0] REG_COUNT = 3'h2;
  localparam logic [2:0] REG_DEVICE = 3'h6;
  localparam logic [2:0] REG_OPCODE = 3'h7;    // command_opcode on write, device_condition on read

  // Opcode of the streaming DMA write
  localparam logic [7:0] OPC_STREAM_WRITE_DMA = 8'h3a;

  // command_options current byte fields
  localparam int OPT_URGENT = 7;
  localparam int OPT_CONTINUE = 6;
  localparam int OPT_FLUSH = 5;
  localparam int OPT_SID_MSB = 2;

  // device_condition fields
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_STREAM_ERR = 5;
  localparam int ST_DREQ = 3;
  localparam int ST_ERR = 0;

  // failure_cause fields
  localparam int FC_ICRC = 7;
  localparam int FC_IDNF = 4;
  localparam int FC_ABORT = 2;
  localparam int FC_TIME_OUT = 0;

  // Reset values
  localparam logic [7:0] CONDITION_RESET = 8'h40;
  localparam logic [7:0] CAUSE_RESET = 8'h00;

  // Transfer geometry
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int WORDS_LEFT_W = 25;
  localparam logic [WORDS_LEFT_W-1:0] WORDS_PER_SECTOR = 25'h0000100;
  localparam logic [WORDS_LEFT_W-1:0] MAX_SECTORS = 25'h0010000;
  localparam int STREAMS = 8;

  // Timing: one microsecond tick from the 50 MHz clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000;
  localparam int CYCLES_PER_US = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] US_DIV_LAST = 6'(CYCLES_PER_US - 1);
  localparam int TIME_W = 40;
  localparam logic [TIME_W-1:0] MIN_LIMIT_US = 40'h00000003e8;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_XFER = 2'b01,
    CMD_FLUSH = 2'b10,
    CMD_END = 2'b11
  } cmd_state_e;

  // Host access to the command block registers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Default time limit set up earlier per stream
  typedef struct packed {
    logic wr;
    logic [2:0] sid;
    logic [7:0] cctl;
  } stream_cfg_s;

  // Error reports from the link and the media side
  typedef struct packed {
    logic icrc;
    logic idnf;
    logic abort;
  } xfer_err_s;

  // Settings handed to the media writer
  typedef struct packed {
    logic active;
    logic urgent;
    logic [2:0] sid;
  } media_ctl_s;

endpackage

// [word_fifo.sv]
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  // Level
  output logic empty_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic out_v;
    logic [WIDTH-1:0] out_d;
  } fifo_s;

  fifo_s s;
  fifo_s next_s;
  logic push;
  logic pop;

  // Output word sits in a register so the drain side sees clean data
  always_comb begin
    next_s = s;
    in_ready_out = (s.count != (AW+1)'(DEPTH));
    push = in_valid_in & in_ready_out;
    pop = (s.count != '0) & (~s.out_v | out_ready_in);
    if (out_ready_in & s.out_v) begin
      next_s.out_v = 1'b0;
    end
    if (pop) begin
      next_s.out_v = 1'b1;
      next_s.out_d = s.mem[s.rp];
      next_s.rp = s.rp + 1'b1;
    end
    if (push) begin
      next_s.mem[s.wp] = in_data_in;
      next_s.wp = s.wp + 1'b1;
    end
    next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_valid_out = s.out_v;
  assign out_data_out = s.out_d;
  assign empty_out = (s.count == '0) & ~s.out_v;

endmodule

// [stream_write_dma_command.sv]
`timescale 1ns/1ps
// Operation
// - Opcode 3Ah selects streaming DMA write
// - Data arrives over DMA, not register transfers
// - Requested option actions finish before completion
// - Urgent flag: fast, always within limit
// - Continue flag: errors never abort command
// - Continue errors: full transfer, stream-error, logged
// - Continue timeout: stop, stream-error, timeout logged
// - Always attempt whole amount within limit
// - Flush flag: stream data on media first
// - Low option bits select configured stream
// - Limit is previous option byte times unit; code raises it to at least 1000 us
// - Sector count 16 bits, zero means 65536
module stream_write_dma_command
  import stream_cmd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Command block register port
  input wire reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic intrq_out,
  // Identify words 99:98, microseconds per limit unit
  input wire logic [31:0] limit_unit_us_in,
  // Stream defaults set up beforehand
  input wire stream_cfg_s stream_cfg_in,
  // DMA data from the host
  input wire logic dma_valid_in,
  input wire logic [WORD_W-1:0] dma_data_in,
  output logic dma_ready_out,
  output logic dma_req_out,
  // Error reports during the command
  input wire xfer_err_s xfer_err_in,
  // Media writer side
  output logic media_valid_out,
  output logic [WORD_W-1:0] media_data_out,
  input wire logic media_ready_in,
  input wire logic media_busy_in,
  output media_ctl_s media_ctl_out
);

  // Whole block state, registered in one place
  typedef struct packed {
    // Command sequencing
    cmd_state_e st;

    // Byte registers, current and previous halves
    logic [7:0] opt_cur;
    logic [7:0] opt_prev;
    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;

    // Host visible ending status and interrupt
    logic [7:0] condition;
    logic [7:0] cause;
    logic intrq;

    // Options latched when the opcode lands
    logic urgent;
    logic cont;
    logic flush;
    logic [2:0] sid;

    // Words still owed by the host
    logic [WORDS_LEFT_W-1:0] words_left;

    // Completion time limit and its microsecond timebase
    logic limit_en;
    logic [TIME_W-1:0] limit_us;
    logic [TIME_W-1:0] elapsed_us;
    logic [5:0] us_div;

    // Why the command ended early
    logic failed;
    logic timed_out;

    // Default limit units per stream
    logic [STREAMS-1:0][7:0] dflt_cctl;

    // Registered read data
    logic [7:0] rdata;
  } ctl_s;

  // Present and next copy of the state
  ctl_s s;
  ctl_s next_s;

  // FIFO handshake and level
  logic fifo_in_ready;
  logic fifo_empty;

  // Word taken from the host this cycle
  logic accept;

  // Values worked out when the opcode lands
  logic [15:0] sectors;
  logic [7:0] units;
  logic [TIME_W-1:0] limit_raw;

  // Error and time limit events
  logic any_err;
  logic expired;

  // Write data goes through a FIFO so a stalled media writer backs off the host
  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(dma_valid_in & dma_req_out),
    .in_data_in(dma_data_in),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(media_valid_out),
    .out_data_out(media_data_out),
    .out_ready_in(media_ready_in),
    .empty_out(fifo_empty)
  );

  // Host is offered data slots only while words remain and room exists
  assign dma_req_out = (s.st == CMD_XFER) & (s.words_left != '0) & ~s.failed;
  assign dma_ready_out = dma_req_out & fifo_in_ready;
  assign accept = dma_valid_in & dma_ready_out;

  // Any reported error type counts, except ICRC during flush; the log keeps each one apart
  assign any_err = xfer_err_in.icrc | xfer_err_in.idnf | xfer_err_in.abort;

  // Limit compared in whole microseconds, so it may run up to one tick late
  assign expired = s.limit_en & (s.elapsed_us >= s.limit_us);

  // Option and count bytes used when the opcode lands
  always_comb begin
    sectors = {s.cnt_prev, s.cnt_cur};
    units = (s.opt_prev != 8'h00) ? s.opt_prev : s.dflt_cctl[s.opt_cur[OPT_SID_MSB:0]];
    limit_raw = TIME_W'(units) * TIME_W'(limit_unit_us_in);
  end

  // Register port, command sequencing and time limit
  always_comb begin
    next_s = s;

    // Stream defaults may be updated at any time
    if (stream_cfg_in.wr) begin
      next_s.dflt_cctl[stream_cfg_in.sid] = stream_cfg_in.cctl;
    end

    // Reads return registered data; reading condition drops the interrupt
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        REG_OPTIONS: next_s.rdata = s.cause;
        REG_OPCODE: begin
          next_s.rdata = s.condition;
          next_s.intrq = 1'b0;
        end
        default: next_s.rdata = 8'h00;
      endcase
    end

    // Microsecond timebase runs only while a command is in flight
    if (s.st == CMD_IDLE) begin
      next_s.us_div = '0;
      next_s.elapsed_us = '0;
    end else if (s.us_div == US_DIV_LAST) begin
      next_s.us_div = '0;
      next_s.elapsed_us = s.elapsed_us + 1'b1;
    end else begin
      next_s.us_div = s.us_div + 1'b1;
    end

    unique case (s.st)
      CMD_IDLE: begin
        // Each write to a byte register pushes current into previous
        if (reg_req_in.wr) begin
          unique case (reg_req_in.addr)
            REG_OPTIONS: begin
              next_s.opt_prev = s.opt_cur;
              next_s.opt_cur = reg_req_in.wdata;
            end
            REG_COUNT: begin
              next_s.cnt_prev = s.cnt_cur;
              next_s.cnt_cur = reg_req_in.wdata;
            end
            REG_OPCODE: begin
              next_s.intrq = 1'b0;
              next_s.cause = CAUSE_RESET;
              if (reg_req_in.wdata == OPC_STREAM_WRITE_DMA) begin
                next_s.st = CMD_XFER;
                next_s.condition = 8'h00;
                next_s.condition[ST_BUSY] = 1'b1;
                next_s.condition[ST_DREQ] = 1'b1;
                next_s.urgent = s.opt_cur[OPT_URGENT];
                next_s.cont = s.opt_cur[OPT_CONTINUE];
                next_s.flush = s.opt_cur[OPT_FLUSH];
                next_s.sid = s.opt_cur[OPT_SID_MSB:0];
                next_s.words_left = ((sectors == 16'h0000) ? MAX_SECTORS : WORDS_LEFT_W'(sectors))
                                    * WORDS_PER_SECTOR;
                next_s.limit_en = (units != 8'h00);
                next_s.limit_us = (limit_raw < MIN_LIMIT_US) ? MIN_LIMIT_US : limit_raw;
                next_s.failed = 1'b0;
                next_s.timed_out = 1'b0;
              end else begin
                // Anything else is not handled here and is refused at once
                next_s.cause[FC_ABORT] = 1'b1;
                next_s.condition = CONDITION_RESET;
                next_s.condition[ST_ERR] = 1'b1;
                next_s.intrq = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end


      // Data phase: count words, log errors, watch the limit
      CMD_XFER: begin
        if (accept) begin
          next_s.words_left = s.words_left - 1'b1;
        end
        if (any_err) begin
          // Error types accumulate in the log in either mode
          next_s.cause[FC_ICRC] = s.cause[FC_ICRC] | xfer_err_in.icrc;
          next_s.cause[FC_IDNF] = s.cause[FC_IDNF] | xfer_err_in.idnf;
          next_s.cause[FC_ABORT] = s.cause[FC_ABORT] | xfer_err_in.abort;
          if (!s.cont) begin
            next_s.failed = 1'b1;
          end
        end
        if (expired) begin
          next_s.cause[FC_TIME_OUT] = 1'b1;
          next_s.timed_out = 1'b1;
          next_s.st = CMD_END;
        end else if ((s.failed | (any_err & ~s.cont)) & ~s.cont) begin
          next_s.st = CMD_END;
        end else if ((s.words_left == '0) | (accept & (s.words_left == WORDS_LEFT_W'(1)))) begin
          // Whole amount moved, with or without continue-mode errors; flush waits for the media
          next_s.st = s.flush ? CMD_FLUSH : CMD_END;
        end
        if (next_s.st != CMD_XFER) begin
          next_s.condition[ST_DREQ] = 1'b0;
        end
      end


      // Flush holds completion until the media has taken every word or the limit expires
      CMD_FLUSH: begin
        if (any_err) begin
          next_s.cause[FC_IDNF] = s.cause[FC_IDNF] | xfer_err_in.idnf;
          next_s.cause[FC_ABORT] = s.cause[FC_ABORT] | xfer_err_in.abort;
        end
        if (expired) begin
          next_s.cause[FC_TIME_OUT] = 1'b1;
          next_s.timed_out = 1'b1;
          next_s.st = CMD_END;
        end else if (fifo_empty & ~media_busy_in) begin
          next_s.st = CMD_END;
        end
      end


      // Ending status written once, interrupt raised with it
      CMD_END: begin
        // Ending status: continue mode reports stream error, else plain error
        next_s.condition = CONDITION_RESET;
        if ((s.cause != CAUSE_RESET) | s.timed_out | s.failed) begin
          next_s.condition[ST_STREAM_ERR] = s.cont;
          next_s.condition[ST_ERR] = ~s.cont;
        end
        next_s.intrq = 1'b1;
        next_s.st = CMD_IDLE;
      end

      default: next_s.st = CMD_IDLE;
    endcase
  end

  // State register; status shows ready and no error out of reset
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0;
      s.condition <= CONDITION_RESET;
      s.cause <= CAUSE_RESET;
      s.st <= CMD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign reg_rdata_out = s.rdata;
  assign intrq_out = s.intrq;
  assign media_ctl_out.active = (s.st != CMD_IDLE);
  assign media_ctl_out.urgent = s.urgent;
  assign media_ctl_out.sid = s.sid;

endmodule

// [stream_write_dma_command_properties.sv]
`timescale 1ns/1ps
module stream_write_dma_command_checker
  import stream_cmd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Watched ports
  input wire reg_req_s reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic intrq_out,
  input wire logic dma_ready_out,
  input wire logic dma_req_out,
  input wire logic media_valid_out,
  input wire logic [WORD_W-1:0] media_data_out,
  input wire logic media_ready_in,
  input wire media_ctl_s media_ctl_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [7:0] opt;
  // Options byte as last written while idle
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      opt <= 8'h00;
    end else if (reg_req_in.wr && reg_req_in.addr == REG_OPTIONS && !media_ctl_out.active) begin
      opt <= reg_req_in.wdata;
    end
  end
  // Opcode write while no command runs
  sequence s_opc;
    reg_req_in.wr && reg_req_in.addr == REG_OPCODE && !media_ctl_out.active;
  endsequence
  sequence s_start;
    s_opc ##0 reg_req_in.wdata == OPC_STREAM_WRITE_DMA;
  endsequence
  a_start_xfer: assert property (s_start |=> media_ctl_out.active && dma_req_out)
    else $error("transfer did not start");
  a_unknown_opc: assert property (s_opc ##0 reg_req_in.wdata != OPC_STREAM_WRITE_DMA
    |=> !media_ctl_out.active ##[0:1] intrq_out) else $error("unknown opcode not ended");
  a_req_active: assert property (dma_req_out |-> media_ctl_out.active)
    else $error("data request outside command");
  a_ready_active: assert property (dma_ready_out |-> media_ctl_out.active)
    else $error("data taken outside command");
  a_done_quiet: assert property ($rose(intrq_out) |-> !dma_req_out && !dma_ready_out)
    else $error("completion while data still wanted");
  a_options_ctl: assert property ($rose(media_ctl_out.active) |-> media_ctl_out.urgent == opt[OPT_URGENT]
    && media_ctl_out.sid == opt[OPT_SID_MSB:0]) else $error("urgent or stream id wrong");
  a_unmapped_zero: assert property (reg_req_in.rd && reg_req_in.addr == REG_DATA
    |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_intrq_clear: assert property (intrq_out && reg_req_in.rd && reg_req_in.addr == REG_OPCODE
    |=> !intrq_out) else $error("interrupt not cleared by status read");
  a_media_hold: assert property (media_valid_out && !media_ready_in
    |=> media_valid_out && $stable(media_data_out)) else $error("media word dropped");
endmodule

// [host_dma_model.sv]
`timescale 1ns/1ps
module host_dma_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Device handshake
  input wire logic dma_req_in,
  input wire logic dma_ready_in,
  input wire logic stall_in,
  output logic dma_valid_out,
  output logic [15:0] dma_data_out
);
  // Word held until taken; idle data toggles so stale values never pass
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dma_valid_out <= 1'b0;
      dma_data_out <= 16'h0000;
    end else if (dma_valid_out && !dma_ready_in) begin
      dma_valid_out <= 1'b1;
    end else begin
      dma_valid_out <= dma_req_in && !stall_in;
      dma_data_out <= dma_valid_out ? dma_data_out + 16'h1357 : ~dma_data_out;
    end
  end
endmodule

// [test_stream_write_dma_command.sv]
`timescale 1ns/1ps
module test_stream_write_dma_command;
  import stream_cmd_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  reg_req_s req = '0;
  stream_cfg_s cfg = '0;
  xfer_err_s xerr = '0;
  media_ctl_s mctl;
  logic [7:0] rdata;
  logic intrq, dvalid, dready, dreq, mvalid;
  logic stall = 1'b0, mready = 1'b0, mbusy = 1'b0;
  logic [WORD_W-1:0] ddata, mdata;
  logic [WORD_W-1:0] q[$];
  int n_fail = 0, samples_checked = 0, cycles = 0;
  bit hold = 0;
  logic [31:0] seed = 32'd31, r;
  always #10 sys_clk_in = ~sys_clk_in;
  stream_write_dma_command u_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .intrq_out(intrq), .limit_unit_us_in(32'h1), .stream_cfg_in(cfg),
    .dma_valid_in(dvalid), .dma_data_in(ddata), .dma_ready_out(dready), .dma_req_out(dreq),
    .xfer_err_in(xerr), .media_valid_out(mvalid), .media_data_out(mdata), .media_ready_in(mready),
    .media_busy_in(mbusy), .media_ctl_out(mctl));
  host_dma_model u_host (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .dma_req_in(dreq),
    .dma_ready_in(dready), .stall_in(stall), .dma_valid_out(dvalid), .dma_data_out(ddata));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: media word %h, model %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: register %h, model %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Random pacing of both sides, plus the hang guard
  always @(posedge sys_clk_in) begin
    r = xs();
    mready <= r[0];
    stall <= hold | r[1];
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      final_report();
    end
  end
  // Word model: what the host handed over must reach media in order
  always @(negedge sys_clk_in) begin
    if (dvalid && dready) q.push_back(ddata);
    if (mvalid && mready) chk_word(mdata, q.size() != 0 ? q.pop_front() : ~mdata);
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_in);
    req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_in);
    req <= '0;
    #1 d = rdata;
  endtask
  // One sector command with an optional error pulse or a stalled host
  task automatic run(input logic [7:0] opt, input logic [7:0] em, input bit tmo);
    logic [7:0] g;
    int n;
    bit e;
    hold = tmo;
    mbusy <= opt[OPT_FLUSH];
    wr(REG_OPTIONS, 8'h01);
    wr(REG_OPTIONS, opt);
    wr(REG_COUNT, 8'h00);
    wr(REG_COUNT, 8'h01);
    wr(REG_OPCODE, OPC_STREAM_WRITE_DMA);
    repeat (30) @(posedge sys_clk_in);
    xerr <= '{icrc: em[FC_ICRC], idnf: em[FC_IDNF], abort: em[FC_ABORT]};
    @(posedge sys_clk_in);
    xerr <= '0;
    if (opt[OPT_FLUSH]) begin
      repeat (1500) @(posedge sys_clk_in);
      chk_reg({7'h0, intrq}, 8'h00);
      mbusy <= 1'b0;
    end
    n = 0;
    while (intrq !== 1'b1 && n < 70000) begin
      @(posedge sys_clk_in);
      n++;
    end
    e = (em != 8'h00) || tmo;
    rd(REG_OPCODE, g);
    chk_reg(g, 8'h40 | (e ? (opt[OPT_CONTINUE] ? 8'h20 : 8'h01) : 8'h00));
    chk_reg({7'h0, intrq}, 8'h00);
    rd(REG_OPTIONS, g);
    chk_reg(g, em | {7'h0, tmo});
    n = 0;
    while (q.size() != 0 && n < 500) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk_reg(8'(q.size()), 8'h00);
  endtask
  logic [7:0] g;
  logic [7:0] masks[3] = '{8'h80, 8'h10, 8'h04};
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rd(REG_OPCODE, g);
    chk_reg(g, CONDITION_RESET);
    rd(REG_OPTIONS, g);
    chk_reg(g, CAUSE_RESET);
    rd(REG_DATA, g);
    chk_reg(g, 8'h00);
    cfg <= '{wr: 1'b1, sid: 3'h3, cctl: 8'h02};
    @(posedge sys_clk_in);
    cfg <= '0;
    run(8'h83, 8'h00, 0);
    run(8'h25, 8'h00, 0);
    foreach (masks[i]) begin
      run(8'h41, masks[i], 0);
      run(8'h02, masks[i], 0);
    end
    wr(REG_OPCODE, 8'hff);
    rd(REG_OPCODE, g);
    chk_reg(g, 8'h41);
    rd(REG_OPTIONS, g);
    chk_reg(g, 8'h04);
    run(8'h40, 8'h00, 1);
    final_report();
  end
endmodule
bind stream_write_dma_command stream_write_dma_command_checker u_chk (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .intrq_out(intrq_out),
  .dma_ready_out(dma_ready_out), .dma_req_out(dma_req_out), .media_valid_out(media_valid_out),
  .media_data_out(media_data_out), .media_ready_in(media_ready_in), .media_ctl_out(media_ctl_out));
